// *** design/rtsc_ctrl.sv ***
// temperature-sense sequencer, rectifier mode control and status registers
// Operation
// - rectifier stays diode-only during start-up
// - half-sync above lockout until entry current
// - full-sync until current below exit level
// - sense pin uses hot and cold thresholds
// - bias window lasts 25 ms each cycle
// - each comparator deglitched for 10 ms
// - bias off, pin high impedance after window
// - 100 ms monitor flags external high drive
// - forced-high pin stops receiver, charge complete
// - pulled-low pin stops receiver, fault
// - die overtemperature stops regulator with hysteresis
// - received power is reported to transmitter
// - power is output plus losses, averaged
// - report below reference by under 375 mW
// - outside window suspends charging until back (code: only during the bias window)
// - shutdown sends end-transfer packet header 0x02
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module rtsc_ctrl
    import rtsc_pkg::*;
#(
    parameter int BIAS_COUNT = BIAS_CYC,
    parameter int MONITOR_COUNT = MONITOR_CYC,
    parameter int DEGLITCH_COUNT = DEGLITCH_CYC,
    parameter int AVG_LOG2 = 4
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire rtsc_cmp_t cmp_in,
    input wire logic rect_above_uvlo_in,
    input wire logic load_above_entry_in,
    input wire logic load_below_exit_in,
    input wire logic die_at_shutdown_in,
    input wire logic die_below_hyst_in,
    input wire logic [15:0] output_power_mw_in,
    input wire logic [15:0] loss_power_mw_in,
    input wire logic avg_sample_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic bias_window_enable_out,
    output logic thermistor_control_pin_oe_out,
    output rtsc_rect_t rect_mode_out,
    output logic regulator_enable_out,
    output logic charge_enable_out,
    output logic receiver_shutdown_out,
    output rtsc_ept_t ept_out,
    output logic [15:0] received_power_mw_out,
    output logic irq_out
);
    rtsc_phase_t phase_reg;
    logic [31:0] timer_reg;
    rtsc_rect_t mode_reg;
    logic die_sd_reg;
    logic ctrl_flag_reg;
    logic [ST_WIDTH-1:0] status_reg;
    logic [ST_WIDTH-1:0] mask_reg;
    logic [15:0] power_reg;
    logic [15:0] power_next;
    logic [31:0] acc_reg;
    logic [7:0] avg_cnt_reg;
    logic shutdown_reg;
    logic ack_reg;
    logic hot_f;
    logic cold_f;
    logic high_f;
    logic low_f;

    wire in_bias = phase_reg == RTSC_BIAS;
    wire bias_done = in_bias && timer_reg >= rtsc_cyc(BIAS_COUNT - 1);
    wire mon_done = !in_bias && timer_reg >= rtsc_cyc(MONITOR_COUNT - 1);

    rtsc_deglitch #(.COUNT(DEGLITCH_COUNT)) u_hot (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .enable_in(clk_en_in),
        .clear_in(!in_bias), .raw_in(cmp_in.hot), .filtered_out(hot_f));
    rtsc_deglitch #(.COUNT(DEGLITCH_COUNT)) u_cold (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .enable_in(clk_en_in),
        .clear_in(!in_bias), .raw_in(cmp_in.cold), .filtered_out(cold_f));
    // monitor comparators use the same filter length to reject pin noise
    rtsc_deglitch #(.COUNT(DEGLITCH_COUNT)) u_high (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .enable_in(clk_en_in),
        .clear_in(in_bias), .raw_in(cmp_in.ctrl_high), .filtered_out(high_f));
    rtsc_deglitch #(.COUNT(DEGLITCH_COUNT)) u_low (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .enable_in(clk_en_in),
        .clear_in(in_bias), .raw_in(cmp_in.ctrl_low), .filtered_out(low_f));

    // rectifier mode
    rtsc_rect_t mode_next;
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            RTSC_DIODE: if (rect_above_uvlo_in) mode_next = RTSC_HALF;
            RTSC_HALF: if (!rect_above_uvlo_in) mode_next = RTSC_DIODE;
                else if (load_above_entry_in) mode_next = RTSC_FULL;
            RTSC_FULL: if (!rect_above_uvlo_in) mode_next = RTSC_DIODE;
                else if (load_below_exit_in) mode_next = RTSC_HALF;
            default: mode_next = RTSC_DIODE;
        endcase
    end

    // events
    wire ev_chg_done = !in_bias && high_f && !ctrl_flag_reg;
    wire ev_fault = !in_bias && low_f;
    wire ev_hot = in_bias && hot_f;
    wire ev_cold = in_bias && cold_f;
    wire temp_bad = hot_f || cold_f;
    wire die_sd_next = die_sd_reg ? !die_below_hyst_in : die_at_shutdown_in;
    wire ev_die = die_sd_next && !die_sd_reg;
    wire ev_mode = mode_next != mode_reg;
    wire trip = ev_chg_done || ev_fault || ev_hot || ev_cold || ev_die;
    wire [ST_WIDTH-1:0] events = {trip, ev_mode, ev_die, ev_fault, ev_chg_done, ev_cold, ev_hot};

    // bus decode
    wire bus_access = avs_read_in || avs_write_in;
    wire wr_status = avs_write_in && ack_reg && avs_address_in == REG_STATUS;
    wire wr_mask = avs_write_in && ack_reg && avs_address_in == REG_MASK;
    wire [ST_WIDTH-1:0] wdata = avs_writedata_in[ST_WIDTH-1:0];
    // set beats clear for an event landing on the clearing write
    wire [ST_WIDTH-1:0] status_next = (status_reg & ~(wr_status ? wdata : '0)) | events;
    wire [31:0] state_word = {24'h0, die_sd_reg, shutdown_reg, ctrl_flag_reg,
        temp_bad, phase_reg == RTSC_MONITOR, 1'b0, mode_reg};
    wire [31:0] rd_mux = (avs_address_in == REG_STATUS) ? {25'h0, status_reg} :
        (avs_address_in == REG_MASK) ? {25'h0, mask_reg} :
        (avs_address_in == REG_STATE) ? state_word :
        (avs_address_in == REG_POWER) ? {16'h0, power_reg} : 32'h0;

    // power average: sum of output and losses over 2^AVG_LOG2 samples
    wire [16:0] sample = {1'b0, output_power_mw_in} + {1'b0, loss_power_mw_in};
    wire avg_last = avg_cnt_reg == 8'((1 << AVG_LOG2) - 1);
    wire [31:0] acc_sum = acc_reg + {15'h0, sample};
    assign power_next = 16'(acc_sum >> AVG_LOG2);

    // end-power-transfer reason: fault codes outrank charge-complete
    wire [7:0] ept_reason = ev_die ? EPT_INT_FAULT :
        (ev_fault || ev_hot || ev_cold) ? EPT_OVERTEMP : EPT_UNKNOWN;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            phase_reg <= RTSC_BIAS;
            timer_reg <= 32'h0;
            mode_reg <= RTSC_DIODE;
            die_sd_reg <= 1'b0;
            ctrl_flag_reg <= 1'b0;
            status_reg <= '0;
            mask_reg <= MASK_RESET[ST_WIDTH-1:0];
            power_reg <= 16'h0;
            acc_reg <= 32'h0;
            avg_cnt_reg <= 8'h0;
            shutdown_reg <= 1'b0;
            ack_reg <= 1'b0;
            avs_readdata_out <= 32'h0;
            ept_out <= '0;
        end else if (clk_en_in) begin
            if (bias_done) begin
                phase_reg <= RTSC_MONITOR;
                timer_reg <= 32'h0;
            end else if (mon_done) begin
                phase_reg <= RTSC_BIAS;
                timer_reg <= 32'h0;
            end else begin
                timer_reg <= timer_reg + 32'h1;
            end
            if (in_bias && bias_done)
                ctrl_flag_reg <= 1'b0;
            else if (ev_chg_done)
                ctrl_flag_reg <= 1'b1;
            mode_reg <= mode_next;
            die_sd_reg <= die_sd_next;
            status_reg <= status_next;
            if (wr_mask)
                mask_reg <= wdata;
            if (ev_chg_done || ev_fault)
                shutdown_reg <= 1'b1;
            ept_out.valid <= trip;
            if (trip) begin
                ept_out.header <= EPT_HEADER;
                ept_out.reason <= ept_reason;
            end
            if (avg_sample_in) begin
                acc_reg <= avg_last ? 32'h0 : acc_sum;
                avg_cnt_reg <= avg_last ? 8'h0 : avg_cnt_reg + 8'h1;
                if (avg_last)
                    power_reg <= power_next;
            end
            ack_reg <= bus_access && !ack_reg;
            if (avs_read_in && !ack_reg)
                avs_readdata_out <= rd_mux;
        end
    end

    // one wait state per access
    assign avs_waitrequest_out = bus_access && !ack_reg;
    assign bias_window_enable_out = in_bias;
    assign thermistor_control_pin_oe_out = in_bias;
    assign rect_mode_out = mode_reg;
    assign regulator_enable_out = !die_sd_reg && !shutdown_reg;
    assign charge_enable_out = regulator_enable_out && !temp_bad;
    assign receiver_shutdown_out = shutdown_reg;
    // reported value is the measured average; transmitter-side margin is calibration
    assign received_power_mw_out = power_reg;
    assign irq_out = |(status_reg & mask_reg);

    a_bias_length: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $rose(bias_window_enable_out) |-> bias_window_enable_out [*8])
        else $error("bias window too short");
    a_pin_release: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !bias_window_enable_out |-> !thermistor_control_pin_oe_out)
        else $error("pin driven outside bias window");
    a_diode_start: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (mode_reg == RTSC_DIODE && !rect_above_uvlo_in && clk_en_in)
        |=> mode_reg == RTSC_DIODE)
        else $error("sync rectifier left diode mode early");
    a_half_entry: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (mode_reg == RTSC_DIODE && rect_above_uvlo_in && clk_en_in)
        |=> mode_reg == RTSC_HALF)
        else $error("half sync not entered");
    a_full_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (mode_reg == RTSC_FULL && rect_above_uvlo_in && !load_below_exit_in && clk_en_in)
        |=> mode_reg == RTSC_FULL)
        else $error("full sync left without low current");
    a_drive_high: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && ev_chg_done) |=> ctrl_flag_reg && receiver_shutdown_out)
        else $error("external drive not recorded");
    a_fault_stop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && ev_fault) |=> receiver_shutdown_out && !regulator_enable_out)
        else $error("fault did not stop receiver");
    a_die_stop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (clk_en_in && die_at_shutdown_in && !die_sd_reg) |=> !regulator_enable_out)
        else $error("regulator on during die shutdown");
    a_ept_header: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ept_out.valid |-> ept_out.header == EPT_HEADER)
        else $error("wrong end-transfer header");
    a_temp_suspend: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (hot_f || cold_f) |-> !charge_enable_out)
        else $error("charging while out of window");
endmodule

// *** design/rtsc_pkg.sv ***
// package for the temperature-sense and rectifier-mode controller
package rtsc_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int BIAS_MS = 25;
    localparam int DEGLITCH_MS = 10;
    localparam int MONITOR_MS = 100;
    localparam int BIAS_CYC = BIAS_MS * (CLK_HZ / 1000);
    localparam int DEGLITCH_CYC = DEGLITCH_MS * (CLK_HZ / 1000);
    localparam int MONITOR_CYC = MONITOR_MS * (CLK_HZ / 1000);
    localparam int LOSS_LIMIT_MW = 375;

    // register byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h8;
    localparam logic [3:0] REG_POWER = 4'hC;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // status bit positions
    localparam int ST_HOT = 0;
    localparam int ST_COLD = 1;
    localparam int ST_CHG_DONE = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_DIE_SD = 4;
    localparam int ST_MODE_CHG = 5;
    localparam int ST_EPT = 6;
    localparam int ST_WIDTH = 7;

    // end-power-transfer packet
    localparam logic [7:0] EPT_HEADER = 8'h02;
    localparam logic [7:0] EPT_UNKNOWN = 8'h00;
    localparam logic [7:0] EPT_OVERTEMP = 8'h03;
    localparam logic [7:0] EPT_INT_FAULT = 8'h02;

    typedef enum logic [1:0] {
        RTSC_DIODE = 2'b00,
        RTSC_HALF = 2'b01,
        RTSC_FULL = 2'b10
    } rtsc_rect_t;

    typedef enum logic [1:0] {
        RTSC_BIAS = 2'b00,
        RTSC_MONITOR = 2'b01
    } rtsc_phase_t;

    typedef struct packed {
        logic hot;
        logic cold;
        logic ctrl_high;
        logic ctrl_low;
    } rtsc_cmp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] header;
        logic [7:0] reason;
    } rtsc_ept_t;

    function automatic logic [31:0] rtsc_cyc(input int cycles);
        return 32'(cycles);
    endfunction
endpackage

// *** design/rtsc_deglitch.sv ***
// synchroniser and deglitch filter for one comparator output
module rtsc_deglitch
    import rtsc_pkg::*;
#(
    parameter int COUNT = DEGLITCH_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic raw_in,
    output logic filtered_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic filtered_next;
    wire differs = sync2_reg != filtered_out;
    wire expired = count_reg >= rtsc_cyc(COUNT - 1);

    // count only while the synced input disagrees with the output
    assign count_next = (clear_in || !differs || expired) ? 32'h0 : count_reg + 32'h1;
    assign filtered_next = clear_in ? 1'b0 : ((differs && expired) ? sync2_reg : filtered_out);

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            count_reg <= 32'h0;
            filtered_out <= 1'b0;
        end else if (enable_in) begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            count_reg <= count_next;
            filtered_out <= filtered_next;
        end
    end
endmodule

// *** bench/rtsc_batt_model.sv ***
// battery-side partner: thermistor comparators and external pin driver
module rtsc_batt_model
    import rtsc_pkg::*;
(
    input wire logic bias_in,
    input wire logic temp_hot_in,
    input wire logic temp_cold_in,
    input wire logic drive_high_in,
    input wire logic drive_low_in,
    output rtsc_cmp_t cmp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // the thermistor only reads back while the pin is biased; the
    // battery-side driver waits for the pin to float before it forces it
    assign cmp_out = '{
        hot: bias_in & temp_hot_in,
        cold: bias_in & temp_cold_in,
        ctrl_high: ~bias_in & drive_high_in,
        ctrl_low: ~bias_in & drive_low_in
    };
endmodule

// *** bench/rtsc_ctrl_tb_top.sv ***
// self-checking bench for the sense sequencer and rectifier mode control
module rtsc_ctrl_tb_top
    import rtsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n, uvlo, above, below, die_sd, die_ok, smp, rd, wr, t_hot, t_cold, d_hi, d_lo;
    logic wt, bias, oe, reg_en, chg_en, shut, irq, en;
    logic [15:0] held;
    logic [15:0] opw, lpw, pwr;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, lfsr;
    logic [6:0] watch;
    rtsc_cmp_t cmp;
    rtsc_rect_t mode;
    rtsc_ept_t end_power_transfer_packet;
    int n_errors, compares;
    logic [63:0] rd_q[$];
    logic [7:0] ept_q[$];

    always #10 clk = ~clk;
    assign watch = {mode == RTSC_FULL, mode == RTSC_HALF, bias, reg_en, shut, chg_en, irq};

    rtsc_ctrl #(.BIAS_COUNT(40), .MONITOR_COUNT(100), .DEGLITCH_COUNT(8), .AVG_LOG2(4)) i_dut (
        .sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en), .cmp_in(cmp),
        .rect_above_uvlo_in(uvlo), .load_above_entry_in(above), .load_below_exit_in(below),
        .die_at_shutdown_in(die_sd), .die_below_hyst_in(die_ok),
        .output_power_mw_in(opw), .loss_power_mw_in(lpw), .avg_sample_in(smp),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wt), .bias_window_enable_out(bias),
        .thermistor_control_pin_oe_out(oe), .rect_mode_out(mode), .regulator_enable_out(reg_en),
        .charge_enable_out(chg_en), .receiver_shutdown_out(shut), .ept_out(end_power_transfer_packet),
        .received_power_mw_out(pwr), .irq_out(irq));
    rtsc_batt_model i_batt (.bias_in(bias), .temp_hot_in(t_hot), .temp_cold_in(t_cold),
        .drive_high_in(d_hi), .drive_low_in(d_lo), .cmp_out(cmp));

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // reads carry expected data d under mask m
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        int k;
        logic busy;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) rd_q.push_back({m, d});
        busy = 1'b1;
        // waitrequest is sampled at the rising edge; release only after it is low
        for (k = 0; k < 50 && busy; k++) begin
            @(posedge clk);
            busy = (wt !== 1'b0);
        end
        wr <= 1'b0;
        rd <= 1'b0;
        if (busy) begin
            n_errors++;
            results();
        end
    endtask

    task automatic waitc(input int k, input logic v);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(negedge clk);
            if (watch[k] === v) begin
                compares++;
                @(posedge clk);
                return;
            end
        end
        n_errors++;
        $display("BAD %0t wait %0d timed out", $time, k);
        results();
    endtask

    task automatic span(input logic lvl, input int exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            check(oe, bias);
        end while (bias === lvl && n < 500);
        check(n, exp);
    endtask

    task automatic power();
        int i;
        logic [31:0] sum;
        sum = 0;
        for (i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            opw <= {6'h00, lfsr[9:0]};
            lpw <= {8'h00, lfsr[23:16]};
            smp <= 1'b1;
            sum += lfsr[9:0] + lfsr[23:16];
            @(posedge clk);
            smp <= 1'b0;
        end
        repeat (4) @(posedge clk);
        check(pwr, sum >> 4);
        bus(1'b0, REG_POWER, sum >> 4, 32'h0000FFFF);
    endtask

    always @(posedge clk) begin
        if (rd && wt === 1'b0) begin
            check(rdata & rd_q[0][63:32], rd_q[0][31:0]);
            void'(rd_q.pop_front());
        end
        if (end_power_transfer_packet.valid === 1'b1) begin
            check(end_power_transfer_packet.header, 32'h00000002);
            if (ept_q.size() > 0) check(end_power_transfer_packet.reason, ept_q.pop_front());
        end
    end

    initial begin
        {rst_n, uvlo, above, die_sd, smp, rd, wr, t_hot, t_cold, d_hi, d_lo} = '0;
        {opw, lpw, addr, wdata} = '0;
        below = 1'b1;
        die_ok = 1'b1;
        en = 1'b1;
        n_errors = 0;
        compares = 0;
        lfsr = 32'h8CF27FB2;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check(mode, RTSC_DIODE);
        check({bias, reg_en, irq}, 32'h6);
        bus(1'b0, REG_MASK, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 4'h2, 32'hFFFFFFFF, 32'h0);
        bus(1'b0, 4'h2, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        uvlo <= 1'b1;
        waitc(5, 1'b1);
        above <= 1'b1;
        below <= 1'b0;
        waitc(6, 1'b1);
        above <= 1'b0;
        repeat (20) @(posedge clk);
        bus(1'b0, REG_STATE, 32'h2, 32'h3);
        below <= 1'b1;
        waitc(5, 1'b1);
        bus(1'b0, REG_STATUS, 32'h20, 32'h20);
        $display("test rectifier done");
        waitc(4, 1'b0);
        waitc(4, 1'b1);
        span(1'b1, 40);
        span(1'b0, 100);
        $display("test window done");
        bus(1'b1, REG_MASK, 32'h1, 32'h0);
        waitc(4, 1'b1);
        // a pulse shorter than the filter must leave no trace
        t_hot <= 1'b1;
        repeat (4) @(posedge clk);
        t_hot <= 1'b0;
        repeat (60) @(posedge clk);
        check(irq, 0);
        t_hot <= 1'b1;
        waitc(0, 1'b1);
        waitc(1, 1'b0);
        t_hot <= 1'b0;
        waitc(1, 1'b1);
        bus(1'b1, REG_STATUS, 32'h1, 32'h0);
        waitc(0, 1'b0);
        t_cold <= 1'b1;
        waitc(1, 1'b0);
        check(irq, 0);
        bus(1'b0, REG_STATUS, 32'h2, 32'h3);
        t_cold <= 1'b0;
        waitc(1, 1'b1);
        $display("test temperature done");
        ept_q.delete();
        ept_q.push_back(8'h02);
        die_ok <= 1'b0;
        die_sd <= 1'b1;
        waitc(3, 1'b0);
        die_sd <= 1'b0;
        repeat (20) @(posedge clk);
        check(reg_en, 0);
        die_ok <= 1'b1;
        waitc(3, 1'b1);
        bus(1'b0, REG_STATUS, 32'h50, 32'h50);
        power();
        // strobes while the clock enable is low must leave the average alone
        held = pwr;
        en <= 1'b0;
        repeat (16) begin
            @(posedge clk);
            smp <= 1'b1;
        end
        @(posedge clk);
        smp <= 1'b0;
        @(posedge clk);
        check(pwr, held);
        en <= 1'b1;
        $display("test die and power done");
        ept_q.delete();
        ept_q.push_back(8'h00);
        d_hi <= 1'b1;
        waitc(2, 1'b1);
        bus(1'b0, REG_STATE, 32'h20, 32'h20);
        d_hi <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h44, 32'h4C);
        ept_q.delete();
        ept_q.push_back(8'h03);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        d_lo <= 1'b1;
        waitc(2, 1'b1);
        bus(1'b0, REG_STATUS, 32'h48, 32'h4C);
        check(ept_q.size(), 0);
        $display("test external drive done");
        results();
    end
endmodule
